// ### bench/spi_peer_model.sv
// Purpose: Far-side serial peer seen by the channel in master mode.
// Assumes: Shift clock and data sampled on the system clock.
// Notes: Released data shows changing bits, never the last value.
`timescale 1ns/1ps

module spi_peer_model (
  input wire logic clk_in,
  input wire logic sclk_in,
  input wire logic mosi_in,
  input wire logic cpol_in,
  input wire logic cpha_in,
  input wire logic load_in,
  input wire logic [15:0] load_data_in,
  output logic miso_out,
  output logic [15:0] rx_data_out
);
  logic prev_q;
  logic [15:0] rx_q;
  logic first_q;
  logic [15:0] tx_q;
  wire edge_w = sclk_in != prev_q;
  // leading edge leaves the idle level
  wire lead_w = sclk_in != cpol_in;

  assign miso_out = tx_q[15];
  assign rx_data_out = rx_q;

  always @(posedge clk_in) begin
    prev_q <= sclk_in;
    if (load_in) begin
      tx_q <= load_data_in;
      rx_q <= 16'h0000;
      first_q <= 1'b1;
    end else if (edge_w) begin
      first_q <= 1'b0;
      // latch and shift on opposite edges
      if (lead_w != cpha_in)
        rx_q <= {rx_q[14:0], mosi_in};
      else if (!first_q)
        tx_q <= {tx_q[14:0], ~tx_q[15]};
    end
  end
endmodule

// ### bench/sync_serial_channel_tb_top.sv
// Purpose: Self-checking bench of the serial channel in master mode.
// Assumes: Peer model on the far side, baud reload of 2.
// Notes: Slave paths are not exercised here.
`timescale 1ns/1ps

module sync_serial_channel_tb_top
  import ssc_pkg::*;
;
  logic clk_sys_in = 1'b0;
  logic arst_n_in = 1'b0;
  logic [ADDR_W-1:0] addr = '0;
  logic [DATA_W-1:0] wdata = '0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic ld = 1'b0;
  logic [15:0] ld_d = '0;
  logic [DATA_W-1:0] rdata_out;
  link_out_t link_out;
  logic tx_irq_out, rx_irq_out, err_irq_out, miso, sclk_q;
  logic [15:0] peer_rx;
  ctrl_t c;
  int mismatches = 0;
  int cmp_count = 0;
  int tgl = 0, gap = 0, badgap = 0, txi = 0, rxi = 0, erri = 0;
  logic [15:0] got;

  // Pull-up on the data line released by an open-drain driver
  wire da_line = link_out.da_oe ? link_out.da : 1'b1;

  sync_serial_channel dut (.clk_sys_in(clk_sys_in), .arst_n_in(arst_n_in),
    .addr_in(addr), .wdata_in(wdata), .wr_in(wr), .rd_in(rd),
    .rdata_out(rdata_out), .sclk_in(link_out.sclk), .da_in(da_line),
    .db_in(miso), .link_out(link_out), .tx_irq_out(tx_irq_out),
    .rx_irq_out(rx_irq_out), .err_irq_out(err_irq_out));

  spi_peer_model peer (.clk_in(clk_sys_in), .sclk_in(link_out.sclk),
    .mosi_in(da_line), .cpol_in(c.cpol), .cpha_in(c.cpha),
    .load_in(ld), .load_data_in(ld_d), .miso_out(miso),
    .rx_data_out(peer_rx));

  initial begin
    forever #4 clk_sys_in = ~clk_sys_in;
  end

  always @(posedge clk_sys_in) begin
    sclk_q <= link_out.sclk;
    gap <= gap + 1;
    if (link_out.sclk != sclk_q) begin
      tgl <= tgl + 1;
      gap <= 1;
      if (tgl > 0 && gap != 3)
        badgap <= badgap + 1;
    end
    if (tx_irq_out) txi <= txi + 1;
    if (rx_irq_out) rxi <= rxi + 1;
    if (err_irq_out) erri <= erri + 1;
  end

  task automatic final_report();
    if (mismatches == 0 && cmp_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  task automatic cmp(input logic [15:0] g, input logic [15:0] e);
    cmp_count++;
    if (g !== e) begin
      mismatches++;
      $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  task automatic wr_reg(input logic [ADDR_W-1:0] a, input logic [15:0] d);
    @(posedge clk_sys_in);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk_sys_in);
    wr <= 1'b0;
  endtask

  task automatic rd_reg(input logic [ADDR_W-1:0] a, output logic [15:0] d);
    @(posedge clk_sys_in);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk_sys_in);
    rd <= 1'b0;
    #1 d = rdata_out;
  endtask

  function automatic logic [15:0] ordr(input logic [15:0] v, input int n,
                                       input logic lsb);
    logic [15:0] r;
    r = '0;
    for (int k = 0; k < n; k++)
      r[k] = lsb ? v[n-1-k] : v[k];
    return r;
  endfunction

  task automatic xfer(input logic [15:0] d, input logic [15:0] p,
                      input bit rdr);
    int n;
    int k;
    n = c.len_m1 + 1;
    // A polarity change toggles the clock once; keep it out of the gap check
    tgl = 0;
    wr_reg(OFF_CTRL, {5'h00, c});
    repeat (3) @(posedge clk_sys_in);
    ld_d <= p;
    ld <= 1'b1;
    @(posedge clk_sys_in);
    ld <= 1'b0;
    tgl = 0;
    txi = 0;
    rxi = 0;
    wr_reg(OFF_TXDATA, d);
    k = 0;
    while (rxi == 0 && k < 400) begin
      @(posedge clk_sys_in);
      k++;
    end
    if (k == 400) begin
      mismatches++;
      final_report();
    end
    cmp(16'(txi), 16'h0001);
    cmp(16'(tgl), 16'(2 * n));
    cmp({15'h0, link_out.sclk}, {15'h0, c.cpol});
    cmp({15'h0, link_out.sclk_oe}, 16'h0001);
    cmp({15'h0, link_out.db_oe}, 16'h0000);
    cmp(peer_rx & ordr(16'hffff, n, 1'b0), ordr(d, n, c.lsb_first));
    if (rdr) begin
      rd_reg(OFF_RXDATA, got);
      if (c.loopback || c.half_duplex)
        cmp(got, ordr(d, n, 1'b0));
      else
        cmp(got, ordr(p >> (16 - n), n, c.lsb_first));
    end
  endtask

  initial begin
    c = CTRL_RST;
    repeat (10) @(posedge clk_sys_in);
    arst_n_in <= 1'b1;
    repeat (3) @(posedge clk_sys_in);
    rd_reg(OFF_CTRL, got);
    cmp(got, 16'h0000);
    rd_reg(OFF_BAUD, got);
    cmp(got, 16'h0000);
    rd_reg(5'h14, got);
    cmp(got, 16'h0000);
    wr_reg(OFF_BAUD, 16'h0002);
    for (int i = 0; i < 8; i++) begin
      c = '{1'b1, 1'b1, 1'b0, 1'b0, i[0], i[1], i[2], 4'(2 * i + 1)};
      xfer(16'ha5c3 ^ 16'(i * 16'h1111), 16'h3c96 + 16'(i), 1'b1);
    end
    c.loopback = 1'b1;
    xfer(16'h5a3c, 16'ha5c3, 1'b1);
    c.loopback = 1'b0;
    c.half_duplex = 1'b1;
    xfer(16'h6b4d, 16'h1e2f, 1'b1);
    c.half_duplex = 1'b0;
    erri = 0;
    xfer(16'h1234, 16'hc3a5, 1'b0);
    xfer(16'h4321, 16'h5a5a, 1'b0);
    cmp(16'(erri), 16'h0001);
    rd_reg(OFF_STATUS, got);
    cmp(got & 16'h0074, 16'h0014);
    wr_reg(OFF_STATUS, 16'h0010);
    rd_reg(OFF_STATUS, got);
    cmp(got & 16'h0070, 16'h0000);
    cmp(16'(badgap), 16'h0000);
    final_report();
  end
endmodule

// ### design/ssc_pkg.sv
// Purpose: Shared constants and types of the synchronous serial channel.
// Assumes: 16-bit register port with byte offsets below.
// Notes: Word offsets are multiples of four.
package ssc_pkg;

  localparam int DATA_W = 16;
  localparam int ADDR_W = 5;
  localparam int CNT_W = 5;
  localparam int ERR_W = 4;

  localparam logic [ADDR_W-1:0] OFF_CTRL = 5'h00;
  localparam logic [ADDR_W-1:0] OFF_BAUD = 5'h04;
  localparam logic [ADDR_W-1:0] OFF_TXDATA = 5'h08;
  localparam logic [ADDR_W-1:0] OFF_RXDATA = 5'h0c;
  localparam logic [ADDR_W-1:0] OFF_STATUS = 5'h10;

  // Status word layout
  localparam int ST_BUSY = 0;
  localparam int ST_TXE = 1;
  localparam int ST_RXF = 2;
  localparam int ST_ERR_LO = 3;

  // Error vector positions
  localparam int ERR_TX = 0;
  localparam int ERR_RX = 1;
  localparam int ERR_PH = 2;
  localparam int ERR_BR = 3;

  localparam int CTRL_W = 11;

  typedef struct packed {
    logic enable;
    logic master;
    logic loopback;
    logic half_duplex;
    logic cpol;
    logic cpha;
    logic lsb_first;
    logic [3:0] len_m1;
  } ctrl_t;

  localparam ctrl_t CTRL_RST = 11'h000;
  localparam logic [DATA_W-1:0] BAUD_RST = 16'h0000;

  typedef struct packed {
    logic sclk;
    logic sclk_oe;
    logic da;
    logic da_oe;
    logic db;
    logic db_oe;
  } link_out_t;

  typedef enum logic {
    ST_IDLE = 1'b0,
    ST_RUN = 1'b1
  } state_t;

endpackage

// ### design/sync_serial_channel.sv
// Purpose: Master/slave synchronous serial channel, SPI capable.
// Assumes: All pins synchronous to clk_sys_in.
// Notes: Pin da is master-out/slave-in, db is master-in/slave-out.
//
// Summary of operation
// - Master makes the shift clock; slave shifts on the external clock.
// - Character length programmable from 2 to 16 bits.
// - Selectable LSB-first or MSB-first shifting.
// - Clock idle level selectable low or high; partners agree.
// - Clock phase picks shift and latch edges; partners agree.
// - Full-duplex or half-duplex on a shared data line.
// - Baud generator covers 20 Mbit/s to 305.18 bit/s at 40 MHz.
// - Separate transmit, receive and error interrupt requests.
// - Transmit request on buffer empty, receive request on buffer full.
// - Transmit and receive errors flag buffer misuse, raise error request.
// - Phase and baud errors flag bad data or clocking.
// - Loop-back routes transmit data to the receiver internally.
// - Three pins whose use follows master or slave mode.
// - SPI compatible in all four polarity and phase combinations.
//
// Decided for this implementation: the address map and the address-and-strobe port.
`timescale 1ns/1ps

module sync_serial_channel
  import ssc_pkg::*;
(
  input wire logic clk_sys_in,
  input wire logic arst_n_in,
  input wire logic [ADDR_W-1:0] addr_in,
  input wire logic [DATA_W-1:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  output logic [DATA_W-1:0] rdata_out,
  input wire logic sclk_in,
  input wire logic da_in,
  input wire logic db_in,
  output link_out_t link_out,
  output logic tx_irq_out,
  output logic rx_irq_out,
  output logic err_irq_out
);

  logic [1:0] rst_sync_q;
  logic rst_n;

  always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      rst_sync_q <= 2'h0;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_q[1];

  ctrl_t ctrl_q;
  state_t st_q, st_d;
  logic [DATA_W-1:0] baud_q, brc_q, brc_d, gap_q, gap_d;
  logic [DATA_W-1:0] tx_buf_q, tx_sh_q, rx_sh_q, rx_buf_q, rdata_q;
  logic [DATA_W-1:0] rx_next, rx_sh_d, rdata_d, tx_src;
  logic [CNT_W-1:0] cnt_q, cnt_d;
  logic [ERR_W-1:0] err_q, err_d, err_set, err_clr;
  logic tx_full_q, rx_full_q, dout_q, sclk_q, sclk_prev_q, din_prev_q;
  logic tx_irq_q, rx_irq_q, err_irq_q;

  // Register decode
  wire wr_ctrl = wr_in && (addr_in == OFF_CTRL);
  wire wr_baud = wr_in && (addr_in == OFF_BAUD);
  wire wr_tx = wr_in && (addr_in == OFF_TXDATA);
  wire wr_stat = wr_in && (addr_in == OFF_STATUS);
  wire rd_rx = rd_in && (addr_in == OFF_RXDATA);

  wire busy = (st_q == ST_RUN);
  wire master_on = ctrl_q.enable && ctrl_q.master;
  wire slave_on = ctrl_q.enable && !ctrl_q.master;

  wire [4:0] len_w = (ctrl_q.len_m1 == 4'h0) ? 5'h02
                   : {1'b0, ctrl_q.len_m1} + 5'h01;
  wire [5:0] two_len = {len_w, 1'b0};
  wire [CNT_W-1:0] last_cnt = CNT_W'(two_len - 6'h01);

  function automatic logic [3:0] bpos(input logic lsb,
                                      input logic [3:0] len4,
                                      input logic [3:0] idx);
    logic [3:0] r;
    r = lsb ? idx : 4'(len4 - 4'h1 - idx);
    return r;
  endfunction

  // Reload 0 gives f/2, reload 16'hffff gives f/131072
  // Master edge every reload plus one cycles
  wire m_edge = master_on && busy && (brc_q == 16'h0000);
  wire s_edge = slave_on && (sclk_in != sclk_prev_q);
  wire edge_w = ctrl_q.master ? m_edge : s_edge;

  wire m_start = master_on && !busy && tx_full_q;
  wire s_start = s_edge && !busy;
  wire start = m_start || s_start;

  wire [3:0] bidx = bpos(ctrl_q.lsb_first, len_w[3:0], cnt_q[4:1]);

  // Latch edge from phase, either polarity
  wire latch = edge_w && (cnt_q[0] == ctrl_q.cpha);
  wire done = edge_w && (cnt_q == last_cnt);

  // Receive line choice for full or half duplex
  wire din_pin = (ctrl_q.master ^ ctrl_q.half_duplex) ? db_in : da_in;
  wire din = ctrl_q.loopback ? dout_q : din_pin;

  always_comb begin
    rx_next = rx_sh_q;
    if (latch) begin
      rx_next[bidx] = din;
    end
  end

  assign rx_sh_d = done ? 16'h0000 : rx_next;
  assign tx_src = busy ? tx_sh_q : tx_buf_q;

  assign cnt_d = done ? 5'h00 : (edge_w ? cnt_q + 5'h01 : cnt_q);
  assign st_d = done ? ST_IDLE : (start ? ST_RUN : st_q);

  wire [3:0] nidx = bpos(ctrl_q.lsb_first, len_w[3:0], cnt_d[4:1]);
  wire [DATA_W-1:0] nsrc = (done || (!busy && !start)) ? tx_buf_q
                         : (start ? tx_buf_q : tx_sh_q);
  // While busy, data moves on shift edges only, held over latch edges; idle, it follows tx_buf_q
  wire shift_upd = !busy || (edge_w && !latch);
  wire dout_d = shift_upd ? nsrc[nidx] : dout_q;

  assign brc_d = (start || m_edge) ? baud_q
               : (busy ? brc_q - 16'h0001 : brc_q);
  assign gap_d = (start || edge_w) ? 16'h0000
               : ((gap_q == 16'hffff) ? gap_q : gap_q + 16'h0001);

  // Overrun and slave start without fresh data
  assign err_set[ERR_RX] = done && rx_full_q && !rd_rx;
  assign err_set[ERR_TX] = s_start && !tx_full_q;
  // Data moving at latch edge, or clock faster than reload
  assign err_set[ERR_PH] = slave_on && latch && !ctrl_q.loopback
                         && (din != din_prev_q);
  assign err_set[ERR_BR] = s_edge && busy && (gap_q < baud_q);
  assign err_clr = wr_stat ? wdata_in[ST_ERR_LO +: ERR_W] : 4'h0;
  // Sticky flags, set wins over clear
  assign err_d = (err_q & ~err_clr) | err_set;

  wire [DATA_W-1:0] status_w = {9'h000, err_q, rx_full_q,
                                !tx_full_q, busy};
  wire [DATA_W-1:0] ctrl_rd = {5'h00, ctrl_q};

  always_comb begin
    rdata_d = 16'h0000;
    if (rd_in) begin
      unique case (addr_in)
        OFF_CTRL: rdata_d = ctrl_rd;
        OFF_BAUD: rdata_d = baud_q;
        OFF_TXDATA: rdata_d = tx_buf_q;
        OFF_RXDATA: rdata_d = rx_buf_q;
        OFF_STATUS: rdata_d = status_w;
        default: rdata_d = 16'h0000;
      endcase
    end
  end

  always_ff @(posedge clk_sys_in or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_q <= CTRL_RST;
      baud_q <= BAUD_RST;
      tx_buf_q <= 16'h0000;
    end else begin
      if (wr_ctrl) begin
        ctrl_q <= ctrl_t'(wdata_in[CTRL_W-1:0]);
      end
      if (wr_baud) begin
        baud_q <= wdata_in;
      end
      if (wr_tx) begin
        tx_buf_q <= wdata_in;
      end
    end
  end

  always_ff @(posedge clk_sys_in or negedge rst_n) begin
    if (!rst_n) begin
      st_q <= ST_IDLE;
      cnt_q <= 5'h00;
      brc_q <= 16'h0000;
      gap_q <= 16'h0000;
      tx_sh_q <= 16'h0000;
      rx_sh_q <= 16'h0000;
    end else begin
      st_q <= st_d;
      cnt_q <= cnt_d;
      brc_q <= brc_d;
      gap_q <= gap_d;
      rx_sh_q <= rx_sh_d;
      if (start) begin
        tx_sh_q <= tx_buf_q;
      end
    end
  end

  // Clock idles at polarity, toggles per edge
  always_ff @(posedge clk_sys_in or negedge rst_n) begin
    if (!rst_n) begin
      sclk_q <= 1'b0;
      dout_q <= 1'b0;
      sclk_prev_q <= 1'b0;
      din_prev_q <= 1'b0;
    end else begin
      sclk_q <= ctrl_q.cpol ^ cnt_d[0];
      dout_q <= dout_d;
      sclk_prev_q <= sclk_in;
      din_prev_q <= din;
    end
  end

  // Buffer flags; set wins over clear
  always_ff @(posedge clk_sys_in or negedge rst_n) begin
    if (!rst_n) begin
      tx_full_q <= 1'b0;
      rx_full_q <= 1'b0;
      rx_buf_q <= 16'h0000;
      err_q <= 4'h0;
    end else begin
      tx_full_q <= wr_tx || (tx_full_q && !start);
      rx_full_q <= done || (rx_full_q && !rd_rx);
      if (done) begin
        rx_buf_q <= rx_next;
      end
      err_q <= err_d;
    end
  end

  always_ff @(posedge clk_sys_in or negedge rst_n) begin
    if (!rst_n) begin
      tx_irq_q <= 1'b0;
      rx_irq_q <= 1'b0;
      err_irq_q <= 1'b0;
      rdata_q <= 16'h0000;
    end else begin
      tx_irq_q <= start;
      rx_irq_q <= done;
      err_irq_q <= |err_set;
      rdata_q <= rdata_d;
    end
  end

  assign tx_irq_out = tx_irq_q;
  assign rx_irq_out = rx_irq_q;
  assign err_irq_out = err_irq_q;
  assign rdata_out = rdata_q;

  // Pin roles follow mode; half duplex drives open-drain style
  wire drv_ok = !ctrl_q.half_duplex || !dout_q;
  assign link_out.sclk = sclk_q;
  assign link_out.sclk_oe = master_on;
  assign link_out.da = dout_q;
  assign link_out.da_oe = master_on && drv_ok;
  assign link_out.db = dout_q;
  assign link_out.db_oe = slave_on && drv_ok;

  // Shift clock toggles seen since the last start, for the length check
  logic [5:0] tgl_seen_q;
  logic sclk_seen_q;

  always_ff @(posedge clk_sys_in or negedge rst_n) begin
    if (!rst_n) begin
      tgl_seen_q <= 6'h00;
      sclk_seen_q <= 1'b0;
    end else begin
      sclk_seen_q <= link_out.sclk;
      if (start) begin
        tgl_seen_q <= 6'h00;
      end else if (link_out.sclk != sclk_seen_q) begin
        tgl_seen_q <= tgl_seen_q + 6'h01;
      end
    end
  end

  default clocking cb @(posedge clk_sys_in);
  endclocking
  default disable iff (!rst_n);

  clk_idle_a: assert property (
    master_on && !busy && $stable(ctrl_q) && $past(!busy)
    |-> link_out.sclk == ctrl_q.cpol)
    else $error("master clock not at idle level");

  baud_gap_a: assert property (
    m_edge && $stable(baud_q) |-> gap_q == baud_q)
    else $error("master edge spacing wrong");

  char_len_a: assert property (
    master_on && done
    |=> (tgl_seen_q + 6'h01) == two_len && link_out.sclk != sclk_seen_q)
    else $error("character length wrong");

  rx_full_a: assert property (
    done |=> rx_irq_out && rx_full_q && rx_buf_q == $past(rx_next))
    else $error("receive completion not reported");

  tx_empty_a: assert property (
    start && !wr_tx |=> tx_irq_out && !tx_full_q)
    else $error("transmit empty not reported");

  rx_over_a: assert property (
    done && rx_full_q && !rd_rx |=> err_q[ERR_RX] && err_irq_out)
    else $error("receive overrun not flagged");

  tx_under_a: assert property (
    s_start && !tx_full_q |=> err_q[ERR_TX] && err_irq_out)
    else $error("transmit error not flagged");

  baud_err_a: assert property (
    s_edge && busy && gap_q < baud_q |=> err_q[ERR_BR])
    else $error("baud error not flagged");

  loop_back_a: assert property (
    latch && ctrl_q.loopback && !done
    |=> rx_sh_q[$past(bidx)] == $past(dout_q))
    else $error("loop-back bit not received");

  slave_pins_a: assert property (
    !ctrl_q.master |-> !link_out.sclk_oe && !link_out.da_oe)
    else $error("slave drives master pins");

  master_pins_a: assert property (
    master_on |-> link_out.sclk_oe && !link_out.db_oe)
    else $error("master pin roles wrong");

  open_drain_a: assert property (
    ctrl_q.half_duplex
    |-> !(link_out.da_oe && link_out.da) && !(link_out.db_oe && link_out.db))
    else $error("half duplex line driven high");

  data_hold_a: assert property (
    master_on && busy && latch |=> $stable(link_out.da))
    else $error("data moved on latch edge");

  err_flag_a: assert property (
    err_irq_out |-> err_q != 4'h0)
    else $error("error request without flag");

endmodule
